// File: logic/motion_detect_defs.vh
`ifndef MOTION_DETECT_DEFS_VH
`define MOTION_DETECT_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_PARAM 12'h000
`define OFS_OTP 12'h004
`define OFS_CMD 12'h008
`define OFS_STATUS 12'h00c
`define OFS_INT_STATUS 12'h010
`define OFS_INT_MASK 12'h014
`define OFS_POSITION 12'h018

// ----------------------------------------
// parameter word field positions
// ----------------------------------------
`define THR_LSB 0
`define DLY_LSB 4
`define ACT_LSB 8
`define DC100_BIT 12

// ----------------------------------------
// command word bits (write one to act)
// ----------------------------------------
`define CMD_FULL_READ 0
`define CMD_SHORT_READ 1

// ----------------------------------------
// status bits
// ----------------------------------------
`define ST_STEPLOSS 0
`define ST_BLOCK 1
`define ST_ABSBLOCK 2
`define ST_ACTIVE 3
`define ST_HALT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTP_RESET 13'h0000

// ----------------------------------------
// sample delays in microseconds
// ----------------------------------------
`define DLY0_US 87
`define DLY1_US 130
`define DLY2_US 174
`define DLY3_US 217
`define DLY4_US 304
`define DLY5_US 391
`define DLY6_US 521
`define DLY7_US 694
`define CLK_MHZ 40
`define US_TO_CYC(u) ((u) * `CLK_MHZ)

`endif

// File: logic/sample_delay_timer.v
`timescale 1ns/1ps
`include "motion_detect_defs.vh"

// counts the back-emf sample delay after a zero crossing
module sample_delay_timer #(
	parameter CW = 16,
	parameter SCALE = 1
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// control
	input wire start,
	input wire [2:0] code,
	// result
	output reg expired
);

	// ----------------------------------------
	// delay lookup
	// ----------------------------------------
	reg [CW-1:0] cnt_reg;
	reg busy_reg;
	reg [31:0] len;

	// delay of the selected code rounded down, never below one cycle
	always @* begin
		case (code)
		3'h0: len = `US_TO_CYC(`DLY0_US) / SCALE;
		3'h1: len = `US_TO_CYC(`DLY1_US) / SCALE;
		3'h2: len = `US_TO_CYC(`DLY2_US) / SCALE;
		3'h3: len = `US_TO_CYC(`DLY3_US) / SCALE;
		3'h4: len = `US_TO_CYC(`DLY4_US) / SCALE;
		3'h5: len = `US_TO_CYC(`DLY5_US) / SCALE;
		3'h6: len = `US_TO_CYC(`DLY6_US) / SCALE;
		default: len = `US_TO_CYC(`DLY7_US) / SCALE;
		endcase
		if (len == 32'h0)
			len = 32'h1;
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// a new crossing restarts the count; sample pulse on timeout
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg <= {CW{1'b0}};
			busy_reg <= 1'b0;
			expired <= 1'b0;
		end else begin
			expired <= 1'b0;
			if (start) begin
				cnt_reg <= len[CW-1:0] - {{(CW-1){1'b0}}, 1'b1};
				busy_reg <= 1'b1;
			end else if (busy_reg) begin
				if (cnt_reg == {CW{1'b0}}) begin
					busy_reg <= 1'b0;
					expired <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

// File: logic/stall_detect.v
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`include "motion_detect_defs.vh"

// back-emf stall detection with apb register access
module stall_detect #(
	parameter PW = 16,
	parameter DLY_SCALE = 1
) (
	// apb slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// motion controller status
	input wire positioning,
	input wire at_max_velocity,
	input wire accel_done,
	input wire full_step,
	input wire full_duty,
	input wire [PW-1:0] internal_position,
	// back-emf front end
	input wire zero_cross,
	input wire [3:0] bemf_level,
	// outputs to motion controller
	output reg hard_stop,
	output reg [PW-1:0] actual_position,
	output reg irq
);

	// ----------------------------------------
	// storage
	// ----------------------------------------
	// ram copy of the motion parameters
	reg [3:0] bemf_threshold_index_reg;
	reg [2:0] bemf_sample_delay_reg;
	reg [2:0] detect_activation_steps_reg;
	reg full_duty_detect_enable_reg;

	// programmed copy and its power-on load request
	reg [12:0] otp_reg;
	reg por_load_reg;

	// sticky motion flags and the position freeze
	reg steploss_reg;
	reg block_reg;
	reg absolute_block_flag_reg;
	reg halt_reg;

	// activation after the ramp
	reg [2:0] step_cnt_reg;
	reg armed_reg;

	// interrupt state
	reg [2:0] int_status_reg;
	reg [2:0] int_mask_reg;

	// sample strobe from the delay timer
	wire sample_now;

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	// one strobe per transfer: the access cycle with ready high
	wire acc = psel && penable && pready;
	wire wr = acc && pwrite;

	// address hits, shared by the write strobes and the read mux
	wire param_hit = paddr == `OFS_PARAM;
	wire otp_hit = paddr == `OFS_OTP;
	wire cmd_hit = paddr == `OFS_CMD;
	wire status_hit = paddr == `OFS_STATUS;
	wire int_status_hit = paddr == `OFS_INT_STATUS;
	wire int_mask_hit = paddr == `OFS_INT_MASK;
	wire position_hit = paddr == `OFS_POSITION;

	// write strobes, one per register
	wire param_wr = wr && param_hit;
	wire otp_wr = wr && otp_hit;
	wire int_status_wr = wr && int_status_hit;
	wire int_mask_wr = wr && int_mask_hit;

	// status-read commands; full wins when both bits are written
	wire full_read = wr && cmd_hit && pwdata[`CMD_FULL_READ];
	wire short_read = wr && cmd_hit && pwdata[`CMD_SHORT_READ]
		&& !pwdata[`CMD_FULL_READ];
	wire any_read = full_read || short_read;
	wire thr_on = bemf_threshold_index_reg != 4'h0;

	// detection gate: on, past ramp and extra steps, at top speed, duty ok
	wire eval_ok = thr_on && armed_reg && at_max_velocity
		&& (!full_duty || full_duty_detect_enable_reg);

	// level compare; index order is level order, so compare codes
	wire stall_hit = sample_now && eval_ok
		&& bemf_level < bemf_threshold_index_reg;

	// ----------------------------------------
	// sample delay
	// ----------------------------------------
	// the timer idles while the index is zero, so no stray strobes
	sample_delay_timer #(
		.CW(16),
		.SCALE(DLY_SCALE)
	) sample_delay_timer_inst (
		.pclk(pclk),
		.presetn(presetn),
		.start(zero_cross && thr_on),
		.code(bemf_sample_delay_reg),
		.expired(sample_now)
	);

	// ----------------------------------------
	// apb handshake
	// ----------------------------------------
	// zero wait states; unmapped reads give zero with an error
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			// ready follows setup by one cycle: no wait states
			pready <= psel && !penable;
			pslverr <= 1'b0;
			// read word and error are captured in the setup cycle
			if (psel && !penable) begin
				prdata <= 32'h0;
				if (param_hit)
					prdata <= {19'h0, full_duty_detect_enable_reg,
						1'b0, detect_activation_steps_reg,
						1'b0, bemf_sample_delay_reg,
						bemf_threshold_index_reg};
				else if (otp_hit)
					prdata <= {19'h0, otp_reg};
				else if (status_hit)
					// value before any clear, as read returns it
					prdata <= {27'h0, halt_reg, armed_reg,
						absolute_block_flag_reg, block_reg,
						steploss_reg};
				else if (int_status_hit)
					prdata <= {29'h0, int_status_reg};
				else if (int_mask_hit)
					prdata <= {29'h0, int_mask_reg};
				else if (position_hit)
					prdata <= {{(32-PW){1'b0}}, actual_position};
				else if (cmd_hit)
					// command word is write-only and reads as zero
					prdata <= 32'h0;
				else
					pslverr <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// parameters and otp copy
	// ----------------------------------------
	// otp reset value cannot be sampled under async reset, so a load
	// flag copies it on the first clock after release
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otp_reg <= `OTP_RESET;
			por_load_reg <= 1'b1;
			bemf_threshold_index_reg <= 4'h0;
			bemf_sample_delay_reg <= 3'h0;
			detect_activation_steps_reg <= 3'h0;
			full_duty_detect_enable_reg <= 1'b0;
		end else begin
			por_load_reg <= 1'b0;
			// the power-on copy wins over a write in the same cycle
			if (por_load_reg) begin
				{full_duty_detect_enable_reg, detect_activation_steps_reg,
					bemf_sample_delay_reg, bemf_threshold_index_reg}
					<= {otp_reg[12], otp_reg[10:8], otp_reg[6:4],
					otp_reg[3:0]};
			end else if (param_wr) begin
				bemf_threshold_index_reg <= pwdata[`THR_LSB+3:`THR_LSB];
				bemf_sample_delay_reg <= pwdata[`DLY_LSB+2:`DLY_LSB];
				detect_activation_steps_reg <= pwdata[`ACT_LSB+2:`ACT_LSB];
				full_duty_detect_enable_reg <= pwdata[`DC100_BIT];
			end
			if (otp_wr)
				otp_reg <= pwdata[12:0];
		end
	end

	// ----------------------------------------
	// activation after ramp plus steps
	// ----------------------------------------
	// any break in the order or the ramp restarts the step count
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt_reg <= 3'h0;
			armed_reg <= 1'b0;
		end else if (!positioning || !accel_done) begin
			step_cnt_reg <= 3'h0;
			armed_reg <= 1'b0;
		end else if (!armed_reg) begin
			if (step_cnt_reg == detect_activation_steps_reg)
				armed_reg <= 1'b1;
			else if (full_step)
				step_cnt_reg <= step_cnt_reg + 3'h1;
		end
	end

	// ----------------------------------------
	// sticky flags
	// ----------------------------------------
	// each flag tests its set first, so a set wins over a clear
	wire stop_now = stall_hit && positioning;

	// step loss: only a stall while positioning counts as lost steps
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			steploss_reg <= 1'b0;
		else if (stop_now)
			steploss_reg <= 1'b1;
		else if (any_read)
			steploss_reg <= 1'b0;
	end

	// blocked rotor: any stall sets it; only the full read clears it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			block_reg <= 1'b0;
		else if (stall_hit)
			block_reg <= 1'b1;
		else if (full_read)
			block_reg <= 1'b0;
	end

	// absolute block shares the set and clear of the blocked rotor
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			absolute_block_flag_reg <= 1'b0;
		else if (stall_hit)
			absolute_block_flag_reg <= 1'b1;
		else if (full_read)
			absolute_block_flag_reg <= 1'b0;
	end

	// ----------------------------------------
	// hard stop and position
	// ----------------------------------------
	// halt freezes the position until either status read releases it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			halt_reg <= 1'b0;
		else if (stop_now)
			halt_reg <= 1'b1;
		else if (any_read)
			halt_reg <= 1'b0;
	end

	// copy on the stop itself, then hold; tracks again once released
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			actual_position <= {PW{1'b0}};
		else if (stop_now || !halt_reg || any_read)
			actual_position <= internal_position;
	end

	// one-cycle stop pulse toward the motion controller
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hard_stop <= 1'b0;
		else
			hard_stop <= stop_now;
	end

	// ----------------------------------------
	// interrupt
	// ----------------------------------------
	// events: steploss, block, absolute block; write one clears
	wire [2:0] int_event = {stall_hit, stall_hit, stop_now};
	wire [2:0] int_clear = int_status_wr ? pwdata[2:0] : 3'h0;

	// mask is plain read and write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_mask_reg <= 3'h0;
		else if (int_mask_wr)
			int_mask_reg <= pwdata[2:0];
	end

	// an event in the clearing cycle stays pending, so none is lost
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			int_status_reg <= 3'h0;
		else
			int_status_reg <= (int_status_reg & ~int_clear) | int_event;
	end

	// level output, registered so it comes straight from a flip-flop
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |(int_status_reg & int_mask_reg);
	end

endmodule

// File: sim/stall_detect_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for stall detect
// ----------------------------------------
module stall_detect_properties #(
	parameter PW = 16,
	parameter DLY_SCALE = 1
) (
	// apb
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// motion
	input wire positioning,
	input wire at_max_velocity,
	input wire zero_cross,
	input wire hard_stop,
	input wire [PW-1:0] actual_position
);
	// shortest sample delay, code zero
	localparam int MIN_DLY = 87 * 40 / DLY_SCALE;
	logic [15:0] since_zc;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// cycles since the last crossing; saturates so it never wraps
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			since_zc <= 16'hffff;
		else if (zero_cross)
			since_zc <= 16'h0000;
		else if (since_zc != 16'hffff)
			since_zc <= since_zc + 16'h0001;
	end
	sequence stop_seen;
		hard_stop ##1 1'b1;
	endsequence
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	chk_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	chk_err_unmapped: assert property (
		pready && paddr > 12'h018 |-> pslverr)
		else $error("no error on unmapped address");
	chk_err_zero: assert property (
		pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("error read not zero");
	chk_stop_speed: assert property (
		hard_stop |-> $past(positioning) && $past(at_max_velocity))
		else $error("stop outside top speed run");
	chk_frozen_pos: assert property (
		stop_seen |=> $stable(actual_position) [*4])
		else $error("position moved after stop");
	chk_sample_delay: assert property (
		hard_stop |-> since_zc >= MIN_DLY)
		else $error("sample taken too early");
endmodule

bind stall_detect stall_detect_properties #(
	.PW(PW),
	.DLY_SCALE(DLY_SCALE)
) chk_inst (
	.pclk(pclk),
	.presetn(presetn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.positioning(positioning),
	.at_max_velocity(at_max_velocity),
	.zero_cross(zero_cross),
	.hard_stop(hard_stop),
	.actual_position(actual_position)
);

// File: sim/motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// motor and ramp stand-in
// ----------------------------------------
module motor_model (
	// clock, reset and bench control
	input wire pclk,
	input wire presetn,
	input wire run,
	input wire hard_stop,
	// motion status toward the block
	output reg positioning,
	output reg at_max_velocity,
	output wire accel_done,
	output wire full_step,
	output wire zero_cross,
	output reg [15:0] internal_position
);
	reg [7:0] tick_reg;
	// ramp ends at a tick wrap; a stop order wins over run
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			positioning <= 1'b0;
			at_max_velocity <= 1'b0;
			tick_reg <= 8'h00;
			internal_position <= 16'h0000;
		end else begin
			tick_reg <= tick_reg + 8'h01;
			positioning <= run && !hard_stop;
			at_max_velocity <= positioning &&
				(at_max_velocity || tick_reg == 8'hff);
			if (full_step)
				internal_position <= internal_position + 16'h0001;
		end
	end
	// crossings every 256 cycles, longer than any scaled delay
	assign accel_done = at_max_velocity;
	assign full_step = positioning && !hard_stop && tick_reg[3:0] == 4'h0;
	assign zero_cross = at_max_velocity && tick_reg == 8'h08;
endmodule

// File: sim/test_stall_detect.sv
`timescale 1ns/1ps
// ----------------------------------------
// bench for stall detect
// ----------------------------------------
module test_stall_detect;
	localparam int SC = 128;
	logic pclk = 1'b0, presetn = 1'b0, run = 1'b0, full_duty = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, hit, hard_stop, irq, accel_done;
	logic positioning, at_max_velocity, full_step, zero_cross;
	logic [3:0] bemf_level = 4'h0;
	logic [15:0] internal_position, actual_position;
	int n_errors = 0, total_checks = 0, cyc = 0, zc_at = 0, d, lim;
	int us[8] = '{87, 130, 174, 217, 304, 391, 521, 694};
	always #12.5 pclk = ~pclk;
	// crossing time stamps for the delay measurement
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (zero_cross)
			zc_at <= cyc;
	end
	stall_detect #(
		.PW(16),
		.DLY_SCALE(SC)
	) stall_detect_inst (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.positioning(positioning),
		.at_max_velocity(at_max_velocity),
		.accel_done(accel_done),
		.full_step(full_step),
		.full_duty(full_duty),
		.internal_position(internal_position),
		.zero_cross(zero_cross),
		.bemf_level(bemf_level),
		.hard_stop(hard_stop),
		.actual_position(actual_position),
		.irq(irq)
	);
	motor_model motor_model_inst (
		.pclk(pclk),
		.presetn(presetn),
		.run(run),
		.hard_stop(hard_stop),
		.positioning(positioning),
		.at_max_velocity(at_max_velocity),
		.accel_done(accel_done),
		.full_step(full_step),
		.zero_cross(zero_cross),
		.internal_position(internal_position)
	);
	task check(input string s, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	// one apb transfer; release costs an idle edge, no double drive
	task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for ready as long as it takes; the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task run_motor(input logic [31:0] prm, input logic fd);
		int n;
		apb(1'b1, 12'h000, prm);
		full_duty <= fd;
		run <= 1'b1;
		hit = 1'b0;
		for (n = 0; n < 1500 && hit !== 1'b1; n++) begin
			@(posedge pclk);
			hit = hard_stop;
		end
		d = cyc - zc_at;
		run <= 1'b0;
		full_duty <= 1'b0;
		// let the last step land so the position copy has caught up
		repeat (3) @(posedge pclk);
	endtask
	task close_out;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		check("param", 32'h0, rd);
		apb(1'b1, 12'h004, 32'h1a5);
		apb(1'b0, 12'h004, 32'h0);
		check("otp", 32'h1a5, rd);
		apb(1'b1, 12'h000, 32'h1777);
		apb(1'b0, 12'h000, 32'h0);
		check("param", 32'h1777, rd);
		apb(1'b1, 12'h020, 32'hffff_ffff);
		apb(1'b0, 12'h020, 32'h0);
		check("unmapped", 32'h0, rd);
		check("slverr", 32'h1, err);
		$display("test registers done");
		// every delay and step code, threshold just above the emf
		for (int c = 0; c < 8; c++) begin
			bemf_level <= 4'(2 * c);
			apb(1'b1, 12'h014, c < 4 ? 32'h7 : 32'h0);
			run_motor({19'h0, c[0], 1'b0, 3'(c), 1'b0, 3'(c), 4'(2 * c + 1)}, c[0]);
			lim = us[c] * 40 / SC;
			check("stall", 32'h1, hit);
			check("delay", 32'h1, d > lim && d <= lim + 3);
			apb(1'b0, 12'h00c, 32'h0);
			check("status", 32'h13, rd & 32'h13);
			apb(1'b0, 12'h018, 32'h0);
			check("position", internal_position, rd);
			check("irq", c < 4, irq);
			if (c == 0) begin
				apb(1'b1, 12'h008, 32'h2);
				apb(1'b0, 12'h00c, 32'h0);
				check("short read", 32'h2, rd & 32'h3);
			end
			apb(1'b1, 12'h008, 32'h1);
			apb(1'b0, 12'h00c, 32'h0);
			check("full read", 32'h0, rd & 32'h17);
			apb(1'b1, 12'h010, 32'h7);
			apb(1'b0, 12'h010, 32'h0);
			check("irq clear", 32'h0, {rd[2:0], irq});
		end
		$display("test stall codes done");
		// equal emf, threshold off, full duty without enable
		for (int i = 0; i < 3; i++) begin
			bemf_level <= i == 0 ? 4'h8 : 4'h2;
			run_motor(i == 1 ? 32'h1000 : 32'h0008, i == 2);
			check("no stall", 32'h0, hit);
			apb(1'b0, 12'h018, 32'h0);
			check("tracking", internal_position, rd);
		end
		$display("test no stall done");
		close_out();
	end
	initial begin
		repeat (40000) @(posedge pclk);
		n_errors++;
		close_out();
	end
endmodule
